//--- inc/idbc_map.vh
// constants for the interleaved dram board control block
`ifndef IDBC_MAP_VH
`define IDBC_MAP_VH
// ----------------------------------------
// address fields
// ----------------------------------------
`define IDBC_REGION_HI       31
`define IDBC_REGION_LO       25
`define IDBC_LOW_ADDR_W      25
`define IDBC_BLK_HI          24
`define IDBC_BLK_LO          5
`define IDBC_SLOT_HI         27
`define IDBC_SLOT_LO         24
`define IDBC_IODEV_HI        17
`define IDBC_IODEV_LO        16
// ----------------------------------------
// data widths and lanes
// ----------------------------------------
`define IDBC_DATA_W          64
`define IDBC_CHECK_W         8
`define IDBC_WORD_W          72
`define IDBC_BYTE_HI         63
`define IDBC_BYTE_LO         56
`define IDBC_RD_EN_BIT       56
`define IDBC_WR_EN_BIT       57
`define IDBC_LED_BIT         58
// ----------------------------------------
// transaction and space codes
// ----------------------------------------
`define IDBC_TT_MEM_RD       5'h01
`define IDBC_TT_MEM_WR       5'h02
`define IDBC_TT_IO_RD        5'h03
`define IDBC_TT_IO_WR        5'h04
`define IDBC_IO_SPACE        4'h1
`define IDBC_DEV_PROM        2'h0
`define IDBC_DEV_BASE        2'h2
`define IDBC_DEV_ENABLE      2'h3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define IDBC_BASE_RST        8'h00
`define IDBC_ENABLE_RST      3'h0
`define IDBC_BANKS           4
`define IDBC_PHASE_NS        20
`define IDBC_CLK_NS          10
`define IDBC_PHASE_CYC       ((`IDBC_PHASE_NS + `IDBC_CLK_NS - 1) / `IDBC_CLK_NS)
`define IDBC_OWN_WIN         3'h2
`endif

//--- src/idbc_strobe_fan.v
// replicates one strobe into four driver groups of three copies
`timescale 1ns/1ns
`default_nettype none
module idbc_strobe_fan #(
	parameter GROUPS = 4,
	parameter COPIES = 3
) (
	input  wire                      strobe_in,
	output wire [GROUPS*COPIES-1:0]  copies_out
);
	assign copies_out = {(GROUPS*COPIES){strobe_in}};
endmodule
`default_nettype wire

//--- src/idbc_skid_buf.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module idbc_skid_buf #(
	parameter WIDTH = 72
) (
	input  wire              ref_clk_in,
	input  wire              sys_rst_in,
	input  wire              in_valid_in,
	output wire              in_ready_out,
	input  wire [WIDTH-1:0]  in_data_in,
	output wire              out_valid_out,
	input  wire              out_ready_in,
	output wire [WIDTH-1:0]  out_data_out
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wptr;
	reg             rptr;
	reg [1:0]       count;
	wire            push;
	wire            pop;
	assign in_ready_out  = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out  = mem[rptr];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;
	always @(posedge ref_clk_in) begin
		if (push) begin
			mem[wptr] <= in_data_in;
		end
	end
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wptr  <= 1'b0;
			rptr  <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				wptr <= ~wptr;
			end
			if (pop) begin
				rptr <= ~rptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

//--- src/idbc_top.v
// backplane interface and memory control of the interleaved dram board
`include "idbc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module idbc_top #(
	parameter SLOT_W = 4
) (
	input  wire                     ref_clk_in,
	input  wire                     sys_rst_in,
	input  wire                     backplane_addr_strobe_n_in,
	input  wire [31:0]              backplane_address_in,
	input  wire [4:0]               trans_type_in,
	input  wire                     byte_size_in,
	input  wire [SLOT_W-1:0]        slot_ident_bus_in,
	input  wire [3:0]               space_code_bus_in,
	input  wire                     cache_owner_n_in,
	input  wire [63:0]              backplane_word_in,
	input  wire [7:0]               backplane_check_bits_in,
	input  wire                     bus_ready_in,
	input  wire [71:0]              read_bus_a_in,
	input  wire [71:0]              read_bus_b_in,
	input  wire [7:0]               prom_byte_in,
	output wire [63:0]              backplane_word_out,
	output wire [7:0]               backplane_check_bits_out,
	output wire                     read_reg_drive_n_out,
	output wire                     read_valid_out,
	output reg                      bus_ack_out,
	output reg                      board_clock_rebuild_out,
	output wire [71:0]              write_bus_out,
	output wire                     wr_drive_a_n_out,
	output wire                     wr_drive_b_n_out,
	output reg  [19:0]              bank0_addr_out,
	output reg  [19:0]              bank1_addr_out,
	output reg  [18:0]              bank23_addr_out,
	output wire [`IDBC_BANKS*24-1:0] row_strobe_n_out,
	output wire [`IDBC_BANKS*24-1:0] col_strobe_n_out,
	output wire [`IDBC_BANKS*24-1:0] store_strobe_n_out,
	output reg  [24:0]              clocked_addr_out,
	output reg                      io_prom_sel_out,
	output wire                     error_led_out,
	output wire                     busy_out
);
	// ----------------------------------------
	// states and timing
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ROW  = 3'h1;
	localparam [2:0] ST_BANK = 3'h2;
	localparam [2:0] ST_IO   = 3'h3;
	localparam [2:0] ST_DONE = 3'h4;
	localparam integer PHASE_CYC = `IDBC_PHASE_CYC;
	reg [2:0]   state;
	reg [1:0]   bank;
	reg [1:0]   phase;
	reg         is_write;
	reg         is_io;
	reg         is_half_hi;
	reg [2:0]   own_cnt;
	reg [7:0]   base_reg;
	reg [2:0]   enable_reg;
	reg [71:0]  write_reg;
	reg [71:0]  merged;
	reg [24:0]  held_strobe_addr;
	reg         strobe_d;
	wire        strobe_act;
	wire        addr_reg_clk_ok_n;
	// ----------------------------------------
	// input synchroniser for the strobe pin
	// ----------------------------------------
	reg [2:0]   strobe_sync;
	reg         strobe_state;
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strobe_sync  <= 3'h7;
			strobe_state <= 1'b1;
		end else begin
			strobe_sync <= {strobe_sync[1:0], backplane_addr_strobe_n_in};
			if (strobe_sync[1] == strobe_sync[2]) begin
				strobe_state <= strobe_sync[2];
			end
		end
	end
	assign strobe_act = ~strobe_state;
	// ----------------------------------------
	// board clock rebuild
	// ----------------------------------------
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			board_clock_rebuild_out <= 1'b0;
		end else begin
			board_clock_rebuild_out <= ~board_clock_rebuild_out;
		end
	end
	// ----------------------------------------
	// address latch and register
	// ----------------------------------------
	// the latch is modelled as a gated register so that the design stays single-clock
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			held_strobe_addr <= 25'h0000000;
			strobe_d         <= 1'b0;
		end else begin
			strobe_d <= strobe_act;
			if (strobe_act) begin
				held_strobe_addr <= backplane_address_in[24:0];
			end
		end
	end
	assign addr_reg_clk_ok_n = ~(strobe_d & ~strobe_act);
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			clocked_addr_out <= 25'h0000000;
		end else if (!addr_reg_clk_ok_n) begin
			clocked_addr_out <= held_strobe_addr;
		end
	end
	always @* begin
		bank0_addr_out  = held_strobe_addr[`IDBC_BLK_HI:`IDBC_BLK_LO];
		bank1_addr_out  = {held_strobe_addr[24:15], clocked_addr_out[14:5]};
		bank23_addr_out = clocked_addr_out[23:5];
	end
	// ----------------------------------------
	// transaction decode
	// ----------------------------------------
	wire is_mem_rd = (trans_type_in == `IDBC_TT_MEM_RD);
	wire is_mem_wr = (trans_type_in == `IDBC_TT_MEM_WR);
	wire is_io_rd  = (trans_type_in == `IDBC_TT_IO_RD);
	wire is_io_wr  = (trans_type_in == `IDBC_TT_IO_WR);
	// eight-bit compare; base bit 0 is stored and read back but never compared
	wire [7:0] mem_cmp_a = {backplane_address_in[`IDBC_REGION_HI:`IDBC_REGION_LO], 1'b0};
	wire [7:0] mem_cmp_b = {base_reg[7:1], 1'b0};
	wire mem_hit = (mem_cmp_a == mem_cmp_b);
	wire mem_rd_ok = is_mem_rd & enable_reg[0];
	wire mem_wr_ok = is_mem_wr & enable_reg[1];
	wire [7:0] io_cmp_a = {space_code_bus_in, backplane_address_in[`IDBC_SLOT_HI:`IDBC_SLOT_LO]};
	wire [7:0] io_cmp_b = {`IDBC_IO_SPACE, slot_ident_bus_in[3:0]};
	wire io_hit = (io_cmp_a == io_cmp_b) & byte_size_in & (is_io_rd | is_io_wr);
	wire start  = strobe_act & ~strobe_d;
	wire addr_taken = ~strobe_act & ~strobe_d; // the clocked address is only valid once the strobe has gone
	assign busy_out = (state != ST_IDLE);
	// ----------------------------------------
	// transaction sequencer
	// ----------------------------------------
	// one pass visits banks 0..3 in order, one 64-bit word each, so a block is always 32 bytes
	wire [1:0] io_dev = clocked_addr_out[`IDBC_IODEV_HI:`IDBC_IODEV_LO];
	wire       rd_push;
	wire       rd_ready;
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state        <= ST_IDLE;
			bank         <= 2'h0;
			phase        <= 2'h0;
			is_write     <= 1'b0;
			is_io        <= 1'b0;
			is_half_hi   <= 1'b0;
			own_cnt      <= 3'h0;
			bus_ack_out  <= 1'b0;
			base_reg     <= `IDBC_BASE_RST;
			enable_reg   <= `IDBC_ENABLE_RST;
			write_reg    <= 72'h000000000000000000;
			io_prom_sel_out <= 1'b0;
		end else begin
			bus_ack_out <= 1'b0;
			case (state)
			ST_IDLE: begin
				own_cnt <= 3'h0;
				if (start && mem_hit && (mem_rd_ok || mem_wr_ok)) begin
					is_write   <= is_mem_wr;
					is_io      <= 1'b0;
					is_half_hi <= backplane_address_in[23];
					state      <= ST_ROW;
				end else if (start && io_hit) begin
					is_write <= is_io_wr;
					is_io    <= 1'b1;
					state    <= ST_IO;
				end
			end
			ST_ROW: begin
				if (own_cnt == `IDBC_OWN_WIN && !cache_owner_n_in) begin
					is_write <= 1'b1;
				end
				own_cnt <= own_cnt + 3'h1;
				bank    <= 2'h0;
				phase   <= 2'h0;
				if (own_cnt == `IDBC_OWN_WIN) begin
					state <= ST_BANK;
				end
			end
			ST_BANK: begin
				if (is_write || rd_ready) begin
					if (phase == PHASE_CYC[1:0]) begin
						phase <= 2'h0;
						if (is_write) begin
							write_reg <= {backplane_check_bits_in, backplane_word_in};
						end
						if (bank == 2'h3) begin
							state <= ST_DONE;
						end else begin
							bank <= bank + 2'h1;
						end
					end else begin
						phase <= phase + 2'h1;
					end
				end
			end
			ST_IO: begin
				io_prom_sel_out <= addr_taken & (io_dev == `IDBC_DEV_PROM);
				if (addr_taken && is_write && io_dev == `IDBC_DEV_BASE) begin
					base_reg <= backplane_word_in[`IDBC_BYTE_HI:`IDBC_BYTE_LO];
				end
				if (addr_taken && is_write && io_dev == `IDBC_DEV_ENABLE) begin
					enable_reg <= backplane_word_in[`IDBC_LED_BIT:`IDBC_RD_EN_BIT];
				end
				if (addr_taken && (is_write || rd_ready)) begin
					state <= ST_DONE;
				end
			end
			ST_DONE: begin
				io_prom_sel_out <= 1'b0;
				bus_ack_out     <= 1'b1;
				state           <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
	assign error_led_out = enable_reg[2];
	// ----------------------------------------
	// strobes and fan-out
	// ----------------------------------------
	wire in_bank = (state == ST_BANK);
	reg [`IDBC_BANKS*2-1:0] ras;
	reg [`IDBC_BANKS*2-1:0] cas;
	reg [`IDBC_BANKS*2-1:0] store_stb;
	integer b;
	always @* begin
		for (b = 0; b < `IDBC_BANKS; b = b + 1) begin
			ras[2*b]   = in_bank & (bank >= b[1:0]) & ~is_half_hi;
			ras[2*b+1] = in_bank & (bank >= b[1:0]) & is_half_hi;
			cas[2*b]   = ras[2*b] & (bank == b[1:0]) & (phase != 2'h0);
			cas[2*b+1] = ras[2*b+1] & (bank == b[1:0]) & (phase != 2'h0);
			store_stb[2*b]   = cas[2*b] & is_write;
			store_stb[2*b+1] = cas[2*b+1] & is_write;
		end
	end
	genvar g;
	generate
		for (g = 0; g < `IDBC_BANKS*2; g = g + 1) begin : fan
			idbc_strobe_fan u_ras (
				.strobe_in  (~ras[g]),
				.copies_out (row_strobe_n_out[g*12+11:g*12])
			);
			idbc_strobe_fan u_cas (
				.strobe_in  (~cas[g]),
				.copies_out (col_strobe_n_out[g*12+11:g*12])
			);
			idbc_strobe_fan u_store (
				.strobe_in  (~store_stb[g]),
				.copies_out (store_strobe_n_out[g*12+11:g*12])
			);
		end
	endgenerate
	// ----------------------------------------
	// write path
	// ----------------------------------------
	assign write_bus_out    = write_reg;
	assign wr_drive_a_n_out = ~(in_bank & is_write & ~bank[0]);
	assign wr_drive_b_n_out = ~(in_bank & is_write & bank[0]);
	// ----------------------------------------
	// read mux and read buffer
	// ----------------------------------------
	wire read_mux_sel0_n = ~(in_bank & ~bank[0]);
	wire read_mux_sel1_n = ~((in_bank & bank[0]) | (state == ST_IO));
	reg [7:0] io_byte;
	always @* begin
		case (io_dev)
		`IDBC_DEV_PROM:   io_byte = prom_byte_in;
		`IDBC_DEV_BASE:   io_byte = base_reg;
		`IDBC_DEV_ENABLE: io_byte = {5'h00, enable_reg};
		default:          io_byte = 8'h00;
		endcase
		if (!read_mux_sel0_n) begin
			merged = read_bus_a_in;
		end else if (is_io) begin
			merged = {read_bus_b_in[71:64], io_byte, read_bus_b_in[55:0]};
		end else begin
			merged = read_bus_b_in;
		end
	end
	// a read line is pushed at the end of its bank phase; a full buffer stalls the sequencer
	assign rd_push = ~is_write & ((in_bank & (phase == PHASE_CYC[1:0])) | ((state == ST_IO) & addr_taken))
		& (~read_mux_sel0_n | ~read_mux_sel1_n);
	wire [71:0] rd_word;
	idbc_skid_buf #(
		.WIDTH (`IDBC_WORD_W)
	) u_rd_buf (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (rd_push),
		.in_ready_out  (rd_ready),
		.in_data_in    (merged),
		.out_valid_out (read_valid_out),
		.out_ready_in  (bus_ready_in),
		.out_data_out  (rd_word)
	);
	assign read_reg_drive_n_out     = ~read_valid_out;
	assign backplane_word_out       = rd_word[63:0];
	assign backplane_check_bits_out = rd_word[71:64];
endmodule
`default_nettype wire

//--- tb/idbc_top_chk.sv
// port assertions for the interleaved dram board control block
`timescale 1ns/1ns
`default_nettype none
module idbc_top_chk (
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        bus_ready_in,
	input wire logic [63:0] backplane_word_out,
	input wire logic [7:0]  backplane_check_bits_out,
	input wire logic        read_reg_drive_n_out,
	input wire logic        read_valid_out,
	input wire logic        bus_ack_out,
	input wire logic        board_clock_rebuild_out,
	input wire logic [19:0] bank1_addr_out,
	input wire logic [18:0] bank23_addr_out,
	input wire logic [95:0] row_strobe_n_out,
	input wire logic [95:0] col_strobe_n_out,
	input wire logic [95:0] store_strobe_n_out,
	input wire logic [24:0] clocked_addr_out,
	input wire logic        wr_drive_a_n_out,
	input wire logic        wr_drive_b_n_out,
	input wire logic        io_prom_sel_out,
	input wire logic        busy_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a group of twelve copies must never split, or one load sees a different strobe
	function automatic logic fan_ok(input logic [95:0] v);
		int g;
		for (g = 0; g < 8; g++) begin
			if (v[g*12+:12] != 12'h000 && v[g*12+:12] != 12'hFFF) return 1'b0;
		end
		return 1'b1;
	endfunction
	sequence seq_ack;
		bus_ack_out;
	endsequence
	sequence seq_quiet;
		!bus_ack_out ##1 !bus_ack_out;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_ACK_PULSE: assert property (seq_ack |=> seq_quiet)
		else $error("ack longer than one cycle or repeated");
	AST_ACK_BUSY: assert property ($rose(bus_ack_out) |-> $past(busy_out))
		else $error("ack without a running sequence");
	AST_READ_DRIVE: assert property (read_reg_drive_n_out == !read_valid_out)
		else $error("read drive enable disagrees with read valid");
	AST_READ_HOLD: assert property (read_valid_out && !bus_ready_in |=>
		read_valid_out && $stable(backplane_word_out) && $stable(backplane_check_bits_out))
		else $error("stalled read word changed or vanished");
	AST_IDLE_STROBES: assert property (!busy_out |-> &row_strobe_n_out && &col_strobe_n_out
		&& &store_strobe_n_out)
		else $error("strobe active while idle");
	AST_FAN: assert property (fan_ok(row_strobe_n_out) && fan_ok(col_strobe_n_out)
		&& fan_ok(store_strobe_n_out))
		else $error("strobe copies disagree");
	AST_BANK1_COL: assert property (bank1_addr_out[9:0] == clocked_addr_out[14:5])
		else $error("bank one column not from clocked address");
	AST_BANK23: assert property (bank23_addr_out == clocked_addr_out[23:5])
		else $error("bank two and three address not from clocked address");
	AST_CLK_TOGGLE: assert property (!$past(sys_rst_in) |->
		board_clock_rebuild_out != $past(board_clock_rebuild_out))
		else $error("board clock did not toggle");
	AST_WR_DRIVE: assert property ((!wr_drive_a_n_out || !wr_drive_b_n_out) |->
		busy_out && (wr_drive_a_n_out != wr_drive_b_n_out))
		else $error("write bus driven while idle or on both buses");
	AST_PROM_SEL: assert property (io_prom_sel_out |-> busy_out && clocked_addr_out[17:16] == 2'h0)
		else $error("prom select without a prom access");
endmodule
`default_nettype wire

//--- tb/idbc_bus_sink.sv
// backplane read sink that collects read words and can stall
`timescale 1ns/1ns
`default_nettype none
module idbc_bus_sink (
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        valid_in,
	input wire logic [63:0] word_in,
	input wire logic [7:0]  check_in,
	input wire logic        stall_in,
	output logic            ready_out,
	output logic [7:0]      count_out
);
	logic [71:0] words [0:15];
	logic        phase;
	// stalling accepts on every other cycle only, so reads are held back but never deadlock
	assign ready_out = !stall_in || phase;
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			phase <= 1'b0;
			count_out <= 8'h00;
		end else begin
			phase <= !phase;
			if (valid_in && ready_out) begin
				words[count_out[3:0]] <= {check_in, word_in};
				count_out <= count_out + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/test_idbc_top.sv
// self-checking bench for the interleaved dram board control block
`include "idbc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module test_idbc_top;
	logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, backplane_addr_strobe_n_in = 1'b1;
	logic        byte_size_in = 1'b0, cache_owner_n_in = 1'b1, stall = 1'b0;
	logic [31:0] backplane_address_in = 32'h00000000;
	logic [4:0]  trans_type_in = 5'h00;
	logic [3:0]  slot_ident_bus_in = 4'h5, space_code_bus_in = 4'h1;
	logic [63:0] backplane_word_in = 64'h0, backplane_word_out;
	logic [7:0]  backplane_check_bits_in = 8'h5A, prom_byte_in = 8'hC3, backplane_check_bits_out, sink_cnt;
	logic [71:0] read_bus_a_in = 72'h3C0123456789ABCDEF, read_bus_b_in = 72'hA5FEDCBA9876543210;
	logic        bus_ready_in, read_reg_drive_n_out, read_valid_out, bus_ack_out, board_clock_rebuild_out;
	logic        wr_drive_a_n_out, wr_drive_b_n_out, io_prom_sel_out, error_led_out, busy_out;
	logic [71:0] write_bus_out;
	logic [19:0] bank0_addr_out, bank1_addr_out;
	logic [18:0] bank23_addr_out;
	logic [95:0] row_strobe_n_out, col_strobe_n_out, store_strobe_n_out;
	logic [24:0] clocked_addr_out;
	int          mismatches = 0, checks_done = 0;
	localparam logic [7:0]  BASE = 8'h46;
	localparam logic [31:0] MA = {BASE[7:1], 25'h0ABCDE0};
	idbc_top idbc_top_inst (.ref_clk_in, .sys_rst_in, .backplane_addr_strobe_n_in, .backplane_address_in,
		.trans_type_in, .byte_size_in, .slot_ident_bus_in, .space_code_bus_in, .cache_owner_n_in,
		.backplane_word_in, .backplane_check_bits_in, .bus_ready_in, .read_bus_a_in, .read_bus_b_in,
		.prom_byte_in, .backplane_word_out, .backplane_check_bits_out, .read_reg_drive_n_out,
		.read_valid_out, .bus_ack_out, .board_clock_rebuild_out, .write_bus_out, .wr_drive_a_n_out,
		.wr_drive_b_n_out, .bank0_addr_out, .bank1_addr_out, .bank23_addr_out, .row_strobe_n_out,
		.col_strobe_n_out, .store_strobe_n_out, .clocked_addr_out, .io_prom_sel_out, .error_led_out, .busy_out);
	idbc_bus_sink idbc_bus_sink_inst (.ref_clk_in, .sys_rst_in, .valid_in(read_valid_out),
		.word_in(backplane_word_out), .check_in(backplane_check_bits_out), .stall_in(stall),
		.ready_out(bus_ready_in), .count_out(sink_cnt));
	always #5 ref_clk_in = ~ref_clk_in;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cmp_bit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic cmp_val(input string n, input logic [71:0] e, input logic [71:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [31:0] io_addr(input logic [1:0] dev);
		return {4'h0, slot_ident_bus_in, 6'h00, dev, 16'h0000};
	endfunction
	// strobe is a six-cycle pulse; address and data hold until ack or a bounded wait, then the address changes to show the hold
	task automatic trans(input logic [31:0] a, input logic [4:0] tt, input logic bs,
		input logic [63:0] d, output logic acked);
		int n;
		acked = 1'b0;
		backplane_address_in = a;
		trans_type_in = tt;
		byte_size_in = bs;
		backplane_word_in = d;
		backplane_addr_strobe_n_in = 1'b0;
		for (n = 0; n < 60 && !acked; n++) begin
			@(posedge ref_clk_in);
			#1;
			if (n == 5) backplane_addr_strobe_n_in = 1'b1;
			if (bus_ack_out === 1'b1) acked = 1'b1;
		end
		backplane_address_in = ~a;
		repeat (6) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		cmp_bit("ack", 1'b0, bus_ack_out);
		cmp_bit("strobes idle", 1'b1, &{row_strobe_n_out, col_strobe_n_out, store_strobe_n_out});
		$display("t_reset done");
	endtask
	task automatic t_refuse;
		logic ok;
		trans(io_addr(2'h2), `IDBC_TT_IO_WR, 1'b0, 64'h0, ok);
		cmp_bit("io not byte", 1'b0, ok);
		trans(io_addr(2'h2) ^ 32'h01000000, `IDBC_TT_IO_WR, 1'b1, 64'h0, ok);
		cmp_bit("io other slot", 1'b0, ok);
		space_code_bus_in = 4'h2;
		trans(io_addr(2'h2), `IDBC_TT_IO_WR, 1'b1, 64'h0, ok);
		cmp_bit("io other space", 1'b0, ok);
		space_code_bus_in = 4'h1;
		$display("t_refuse done");
	endtask
	task automatic t_setup;
		logic ok;
		trans(io_addr(2'h2), `IDBC_TT_IO_WR, 1'b1, {BASE, 56'h0}, ok);
		cmp_bit("base write", 1'b1, ok);
		trans(MA, `IDBC_TT_MEM_RD, 1'b0, 64'h0, ok);
		cmp_bit("read before enable", 1'b0, ok);
		trans(io_addr(2'h3), `IDBC_TT_IO_WR, 1'b1, {8'h01, 56'h0}, ok);
		cmp_bit("enable write", 1'b1, ok);
		trans(MA, `IDBC_TT_MEM_WR, 1'b0, 64'h0, ok);
		cmp_bit("write not enabled", 1'b0, ok);
		$display("t_setup done");
	endtask
	task automatic t_mem_read;
		logic       ok;
		logic [7:0] c;
		int         i;
		trans(MA ^ 32'h02000000, `IDBC_TT_MEM_RD, 1'b0, 64'h0, ok);
		cmp_bit("region miss", 1'b0, ok);
		c = sink_cnt;
		stall = 1'b1;
		trans(MA, `IDBC_TT_MEM_RD, 1'b0, 64'h0, ok);
		stall = 1'b0;
		cmp_bit("read hit", 1'b1, ok);
		cmp_val("word count", 72'd4, 72'(sink_cnt - c));
		for (i = 0; i < 4; i++) begin
			cmp_val("line", i[0] ? read_bus_b_in : read_bus_a_in,
				idbc_bus_sink_inst.words[4'(c + i)]);
		end
		cmp_val("clocked addr", 72'(MA[24:0]), 72'(clocked_addr_out));
		cmp_val("bank0 addr", 72'(MA[24:5]), 72'(bank0_addr_out));
		$display("t_mem_read done");
	endtask
	task automatic t_io;
		logic       ok;
		logic [7:0] c;
		trans(io_addr(2'h3), `IDBC_TT_IO_WR, 1'b1, {8'h07, 56'h0}, ok);
		cmp_bit("led on", 1'b1, error_led_out);
		c = sink_cnt;
		trans(io_addr(2'h0), `IDBC_TT_IO_RD, 1'b1, 64'h0, ok);
		cmp_bit("prom read", 1'b1, ok);
		cmp_val("prom byte", 72'(prom_byte_in), 72'(idbc_bus_sink_inst.words[c[3:0]][63:56]));
		trans(io_addr(2'h2), `IDBC_TT_IO_RD, 1'b1, 64'h0, ok);
		cmp_val("base byte", 72'(BASE), 72'(idbc_bus_sink_inst.words[4'(c + 8'h01)][63:56]));
		cmp_val("io clocked addr", 72'(io_addr(2'h2) & 32'h01FFFFFF), 72'(clocked_addr_out));
		$display("t_io done");
	endtask
	task automatic t_mem_write;
		logic       ok;
		logic [7:0] c;
		trans(MA + 32'h20, `IDBC_TT_MEM_WR, 1'b0, 64'h1122334455667788, ok);
		cmp_bit("write hit", 1'b1, ok);
		cmp_val("write word", {8'h5A, 64'h1122334455667788}, write_bus_out);
		c = sink_cnt;
		cache_owner_n_in = 1'b0;
		trans(MA + 32'h40, `IDBC_TT_MEM_RD, 1'b0, 64'h8877665544332211, ok);
		cache_owner_n_in = 1'b1;
		cmp_bit("owner read acked", 1'b1, ok);
		cmp_val("owner read words", 72'd0, 72'(sink_cnt - c));
		cmp_val("owner write word", {8'h5A, 64'h8877665544332211}, write_bus_out);
		$display("t_mem_write done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk_in);
		#1;
		sys_rst_in = 1'b0;
		t_reset;
		t_refuse;
		t_setup;
		t_mem_read;
		t_io;
		t_mem_write;
		test_done;
	end
	// fourteen transactions of under eighty cycles each fit well inside this span
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
endmodule
bind idbc_top idbc_top_chk idbc_top_chk_inst (.ref_clk_in, .sys_rst_in, .bus_ready_in, .backplane_word_out,
	.backplane_check_bits_out, .read_reg_drive_n_out, .read_valid_out, .bus_ack_out, .board_clock_rebuild_out,
	.bank1_addr_out, .bank23_addr_out, .row_strobe_n_out, .col_strobe_n_out, .store_strobe_n_out,
	.clocked_addr_out, .busy_out, .wr_drive_a_n_out, .wr_drive_b_n_out, .io_prom_sel_out);
`default_nettype wire
